// ---- core/lcis_map.svh ----
// Purpose: register offsets, field positions and select codes of the cell input side
// Assumes: byte addresses on an 8-bit Wishbone address, one 32-bit word per register
// Notes:   definitions only
`ifndef LCIS_MAP_SVH
`define LCIS_MAP_SVH

// register byte offsets
`define LCIS_OFF_SEL       8'h00
`define LCIS_OFF_GLSL      8'h04
`define LCIS_OFF_GLSH      8'h08
`define LCIS_OFF_POL       8'h0c
`define LCIS_OFF_STAT      8'h10

// reset values
`define LCIS_RST_16        16'h0000
`define LCIS_RST_POL       4'h0

// source select field positions (3 bits each, bit above unimplemented)
`define LCIS_MUX1_LSB      0
`define LCIS_MUX2_LSB      4
`define LCIS_MUX3_LSB      8
`define LCIS_MUX4_LSB      12
`define LCIS_SEL_IMPL      16'h7777

// select codes
`define LCIS_CODE0         3'h0
`define LCIS_CODE1         3'h1
`define LCIS_CODE2         3'h2
`define LCIS_CODE3         3'h3
`define LCIS_CODE4         3'h4
`define LCIS_CODE5         3'h5
`define LCIS_CODE6         3'h6
`define LCIS_CODE7         3'h7

// positions in the synchronised asynchronous input vector
`define LCIS_AS_PIN_A      0
`define LCIS_AS_PIN_B      1
`define LCIS_AS_PIN_C      2
`define LCIS_AS_PIN_D      3
`define LCIS_AS_PCMP1      4
`define LCIS_AS_SCMP1      5
`define LCIS_AS_SCMP2      6
`define LCIS_AS_SCMP3      7
`define LCIS_AS_RCELL2     8
`define LCIS_AS_SYSCLK     9
`define LCIS_AS_RCCLK      10
`define LCIS_AS_REFCLK     11
`define LCIS_AS_N          12

`endif

// ---- core/lcis_pkg.sv ----
// Purpose: shared types of the cell input side
// Assumes: nothing
// Notes:   four data-source muxes of eight inputs each
package lcis_pkg;
   typedef logic [2:0]       lcis_code_t;
   typedef logic [7:0]       lcis_srcvec_t;
   typedef lcis_code_t [3:0] lcis_codes_t;
   typedef lcis_srcvec_t [3:0] lcis_srcs_t;
endpackage

// ---- core/lcis_src_if.sv ----
// Purpose: carries select codes, candidate sources and mux outputs
// Assumes: single clock domain, purely combinational content
// Notes:   index 0 is mux 1
`timescale 1ns/10ps
interface lcis_src_if;
   lcis_pkg::lcis_codes_t sel;
   lcis_pkg::lcis_srcs_t  src;
   logic [3:0]            out;

   modport ctrl
   (
      output sel,
      output src,
      input  out
   );
   modport mux
   (
      input  sel,
      input  src,
      output out
   );
endinterface

// ---- core/lcis_mux.sv ----
// Purpose: the four eight-way data-source selectors
// Assumes: reserved positions already tied low by the caller
// Notes:   combinational, no state
`timescale 1ns/10ps
module lcis_mux
(
   // source side
   lcis_src_if.mux sp
);
   always_comb
   begin
      for (int m = 0; m < 4; m++)
      begin
         sp.out[m] = sp.src[m][sp.sel[m]];
      end
   end
endmodule

// ---- core/lcis_top.sv ----
// Purpose: input side of a configurable logic cell: source muxes and input gates
// Assumes: 20 MHz clk_i, classic Wishbone slave, same-clock peripheral inputs
// Notes:   pins, comparators, clocks and the other core's cell pass two flops first
//
// Overview of operation
// - primary mux 3 codes 7..0: cap4 flag, cap3 flag, cell4, rx, spi out, scmp1, cell1, pin C
// - secondary mux 3 uses the same codes with its own units and pins
// - primary mux 2: cap2 flag, cap1 flag, reserved, reserved, tx, pcmp1, other cell2, pin B
// - secondary mux 2: own flags, reserved, own tx, primary cmp1, primary cell2, pin B
// - primary mux 1: aux4, aux2, scmp3, refclk, rc clock, cell3, system clock, pin A
// - secondary mux 1 same order with own sources, code 5 still secondary cmp3
// - mux 4: aux3, aux1, pin D, reserved, spi in, scmp2, cell2, pwm event A
// - spi input and output choices count only when routed through pin selection
// - gate 1 enables are low-select bits 7..0, source 4 first, true above negated
// - gate 2 enables are low-select bits 15..8 in the same order
// - gate 3 enables are high-select bits 7..0 in the same order
// - gate 4 enables are high-select bits 15..8 in the same order
// - negated enable passes inverted mux output, true enable the plain one, zero excludes
// - source-select bits 15, 11, 7, 3 read zero; fields sit below them
// - each mux offers its true and inverted output to every gate
// - gates OR enabled signals; none enabled gives a constant set by polarity
// - polarity bit one inverts the gate output, zero passes it
`timescale 1ns/10ps
`include "lcis_map.svh"
module lcis_top
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // asynchronous sources
   input  wire logic        cell_pin_a_i,
   input  wire logic        cell_pin_b_i,
   input  wire logic        cell_pin_c_i,
   input  wire logic        cell_pin_d_i,
   input  wire logic        primary_cmp1_i,
   input  wire logic        secondary_cmp1_i,
   input  wire logic        secondary_cmp2_i,
   input  wire logic        secondary_cmp3_i,
   input  wire logic        remote_cell2_i,
   input  wire logic        instruction_cycle_clock_i,
   input  wire logic        internal_rc_clock_i,
   input  wire logic        reference_clock_out_i,
   // same-clock sources
   input  wire logic [3:0]  capture_event_flag_i,
   input  wire logic [3:0]  capture_aux_i,
   input  wire logic [3:0]  cell_out_i,
   input  wire logic        uart1_rx_i,
   input  wire logic        uart1_tx_i,
   input  wire logic        spi1_sdo_i,
   input  wire logic        spi1_sdi_i,
   input  wire logic        spi1_sdo_routed_i,
   input  wire logic        spi1_sdi_routed_i,
   input  wire logic        pwm_event_a_i,
   // gate outputs towards the logic function, registered mux outputs
   output logic      [3:0]  gate_o,
   output logic      [3:0]  mux_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic gate_eval(input logic [7:0] en, input logic [3:0] m);
      logic [7:0] cand;
      cand = {m[3], ~m[3], m[2], ~m[2], m[1], ~m[1], m[0], ~m[0]};
      return |(en & cand);
   endfunction

   function automatic logic [15:0] lane_write(input logic [15:0] old,
                                              input logic [15:0] din,
                                              input logic [1:0]  be);
      logic [15:0] res;
      res = old;
      if (be[0])
      begin
         res[7:0] = din[7:0];
      end
      if (be[1])
      begin
         res[15:8] = din[15:8];
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // synchronisers for inputs from other domains

   logic [`LCIS_AS_N-1:0] async_in;
   logic [`LCIS_AS_N-1:0] meta_reg;
   logic [`LCIS_AS_N-1:0] sync_reg;

   always_comb
   begin
      async_in                  = '0;
      async_in[`LCIS_AS_PIN_A]  = cell_pin_a_i;
      async_in[`LCIS_AS_PIN_B]  = cell_pin_b_i;
      async_in[`LCIS_AS_PIN_C]  = cell_pin_c_i;
      async_in[`LCIS_AS_PIN_D]  = cell_pin_d_i;
      async_in[`LCIS_AS_PCMP1]  = primary_cmp1_i;
      async_in[`LCIS_AS_SCMP1]  = secondary_cmp1_i;
      async_in[`LCIS_AS_SCMP2]  = secondary_cmp2_i;
      async_in[`LCIS_AS_SCMP3]  = secondary_cmp3_i;
      async_in[`LCIS_AS_RCELL2] = remote_cell2_i;
      async_in[`LCIS_AS_SYSCLK] = instruction_cycle_clock_i;
      async_in[`LCIS_AS_RCCLK]  = internal_rc_clock_i;
      async_in[`LCIS_AS_REFCLK] = reference_clock_out_i;
   end

   // clock sources above 10 MHz alias here; they are sampled, not used as clocks
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   logic [15:0] src_sel_reg;
   logic [15:0] gl_low_reg;
   logic [15:0] gl_high_reg;
   logic [3:0]  pol_reg;
   logic        access;
   logic        wr_now;
   logic [7:0]  byte_adr;
   logic [31:0] rd_next;

   assign access   = wb_cyc_i & wb_stb_i;
   assign wr_now   = access & wb_we_i & wb_ack_o;
   assign byte_adr = {wb_adr_i[7:2], 2'b00};

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         src_sel_reg <= `LCIS_RST_16;
      end
      else if (wr_now && byte_adr == `LCIS_OFF_SEL)
      begin
         src_sel_reg <= lane_write(src_sel_reg, wb_dat_i[15:0], wb_sel_i[1:0])
                        & `LCIS_SEL_IMPL;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         gl_low_reg <= `LCIS_RST_16;
      end
      else if (wr_now && byte_adr == `LCIS_OFF_GLSL)
      begin
         gl_low_reg <= lane_write(gl_low_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         gl_high_reg <= `LCIS_RST_16;
      end
      else if (wr_now && byte_adr == `LCIS_OFF_GLSH)
      begin
         gl_high_reg <= lane_write(gl_high_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pol_reg <= `LCIS_RST_POL;
      end
      else if (wr_now && byte_adr == `LCIS_OFF_POL && wb_sel_i[0])
      begin
         pol_reg <= wb_dat_i[3:0];
      end
   end

   always_comb
   begin
      case (byte_adr)
         `LCIS_OFF_SEL:  rd_next = {16'h0000, src_sel_reg & `LCIS_SEL_IMPL};
         `LCIS_OFF_GLSL: rd_next = {16'h0000, gl_low_reg};
         `LCIS_OFF_GLSH: rd_next = {16'h0000, gl_high_reg};
         `LCIS_OFF_POL:  rd_next = {28'h0000000, pol_reg};
         `LCIS_OFF_STAT: rd_next = {24'h000000, mux_o, gate_o};
         default:        rd_next = 32'h00000000;
      endcase
   end

   // one wait state: ack one edge after the request, dropped the edge after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= access & ~wb_ack_o;
         if (access && !wb_ack_o)
         begin
            wb_dat_o <= rd_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // data-source candidates

   lcis_src_if sp ();
   lcis_pkg::lcis_srcs_t src_vec;

   assign sp.sel[0] = src_sel_reg[`LCIS_MUX1_LSB +: 3];
   assign sp.sel[1] = src_sel_reg[`LCIS_MUX2_LSB +: 3];
   assign sp.sel[2] = src_sel_reg[`LCIS_MUX3_LSB +: 3];
   assign sp.sel[3] = src_sel_reg[`LCIS_MUX4_LSB +: 3];
   assign sp.src    = src_vec;

   // port naming already makes the primary and secondary maps identical
   always_comb
   begin
      src_vec = '0;
      // mux 1
      src_vec[0][`LCIS_CODE7] = capture_aux_i[3];
      src_vec[0][`LCIS_CODE6] = capture_aux_i[1];
      src_vec[0][`LCIS_CODE5] = sync_reg[`LCIS_AS_SCMP3];
      src_vec[0][`LCIS_CODE4] = sync_reg[`LCIS_AS_REFCLK];
      src_vec[0][`LCIS_CODE3] = sync_reg[`LCIS_AS_RCCLK];
      src_vec[0][`LCIS_CODE2] = cell_out_i[2];
      src_vec[0][`LCIS_CODE1] = sync_reg[`LCIS_AS_SYSCLK];
      src_vec[0][`LCIS_CODE0] = sync_reg[`LCIS_AS_PIN_A];
      // mux 2
      src_vec[1][`LCIS_CODE7] = capture_event_flag_i[1];
      src_vec[1][`LCIS_CODE6] = capture_event_flag_i[0];
      src_vec[1][`LCIS_CODE5] = 1'b0;
      src_vec[1][`LCIS_CODE4] = 1'b0;
      src_vec[1][`LCIS_CODE3] = uart1_tx_i;
      src_vec[1][`LCIS_CODE2] = sync_reg[`LCIS_AS_PCMP1];
      src_vec[1][`LCIS_CODE1] = sync_reg[`LCIS_AS_RCELL2];
      src_vec[1][`LCIS_CODE0] = sync_reg[`LCIS_AS_PIN_B];
      // mux 3
      src_vec[2][`LCIS_CODE7] = capture_event_flag_i[3];
      src_vec[2][`LCIS_CODE6] = capture_event_flag_i[2];
      src_vec[2][`LCIS_CODE5] = cell_out_i[3];
      src_vec[2][`LCIS_CODE4] = uart1_rx_i;
      src_vec[2][`LCIS_CODE3] = spi1_sdo_i & spi1_sdo_routed_i;
      src_vec[2][`LCIS_CODE2] = sync_reg[`LCIS_AS_SCMP1];
      src_vec[2][`LCIS_CODE1] = cell_out_i[0];
      src_vec[2][`LCIS_CODE0] = sync_reg[`LCIS_AS_PIN_C];
      // mux 4
      src_vec[3][`LCIS_CODE7] = capture_aux_i[2];
      src_vec[3][`LCIS_CODE6] = capture_aux_i[0];
      src_vec[3][`LCIS_CODE5] = sync_reg[`LCIS_AS_PIN_D];
      src_vec[3][`LCIS_CODE4] = 1'b0;
      src_vec[3][`LCIS_CODE3] = spi1_sdi_i & spi1_sdi_routed_i;
      src_vec[3][`LCIS_CODE2] = sync_reg[`LCIS_AS_SCMP2];
      src_vec[3][`LCIS_CODE1] = cell_out_i[1];
      src_vec[3][`LCIS_CODE0] = pwm_event_a_i;
   end

   lcis_mux u_mux
   (
      .sp (sp.mux)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // input gates; registered so the outputs come straight from flops

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         gate_o <= 4'h0;
         mux_o  <= 4'h0;
      end
      else
      begin
         mux_o     <= sp.out;
         gate_o[0] <= gate_eval(gl_low_reg[7:0], sp.out) ^ pol_reg[0];
         gate_o[1] <= gate_eval(gl_low_reg[15:8], sp.out) ^ pol_reg[1];
         gate_o[2] <= gate_eval(gl_high_reg[7:0], sp.out) ^ pol_reg[2];
         gate_o[3] <= gate_eval(gl_high_reg[15:8], sp.out) ^ pol_reg[3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   property p_mux3_cell4;
      @(posedge clk_i) disable iff (rst_i)
      sp.sel[2] == `LCIS_CODE5 |-> sp.out[2] == cell_out_i[3];
   endproperty
   a_mux3_cell4: assert property (p_mux3_cell4)
      else $error("mux 3 code 5 does not pass cell 4");

   property p_mux3_pin;
      @(posedge clk_i) disable iff (rst_i)
      sp.sel[2] == `LCIS_CODE0 |-> sp.out[2] == sync_reg[`LCIS_AS_PIN_C];
   endproperty
   a_mux3_pin: assert property (p_mux3_pin)
      else $error("mux 3 code 0 does not pass pin C");

   property p_mux2_rsvd;
      @(posedge clk_i) disable iff (rst_i)
      (sp.sel[1] == `LCIS_CODE5 || sp.sel[1] == `LCIS_CODE4) |-> !sp.out[1];
   endproperty
   a_mux2_rsvd: assert property (p_mux2_rsvd)
      else $error("reserved mux 2 code not low");

   property p_mux2_cmp;
      @(posedge clk_i) disable iff (rst_i)
      sp.sel[1] == `LCIS_CODE2 |-> sp.out[1] == sync_reg[`LCIS_AS_PCMP1];
   endproperty
   a_mux2_cmp: assert property (p_mux2_cmp)
      else $error("mux 2 code 2 does not pass comparator 1");

   property p_mux2_cell;
      @(posedge clk_i) disable iff (rst_i)
      sp.sel[1] == `LCIS_CODE1 |-> sp.out[1] == sync_reg[`LCIS_AS_RCELL2];
   endproperty
   a_mux2_cell: assert property (p_mux2_cell)
      else $error("mux 2 code 1 does not pass the other cell 2");

   property p_mux1_sys;
      @(posedge clk_i) disable iff (rst_i)
      sp.sel[0] == `LCIS_CODE1 |-> sp.out[0] == sync_reg[`LCIS_AS_SYSCLK];
   endproperty
   a_mux1_sys: assert property (p_mux1_sys)
      else $error("mux 1 code 1 does not pass system clock");

   property p_mux1_cmp3;
      @(posedge clk_i) disable iff (rst_i)
      sp.sel[0] == `LCIS_CODE5 |-> sp.out[0] == sync_reg[`LCIS_AS_SCMP3];
   endproperty
   a_mux1_cmp3: assert property (p_mux1_cmp3)
      else $error("mux 1 code 5 does not pass comparator 3");

   property p_mux4_pin;
      @(posedge clk_i) disable iff (rst_i)
      sp.sel[3] == `LCIS_CODE5 |-> sp.out[3] == sync_reg[`LCIS_AS_PIN_D];
   endproperty
   a_mux4_pin: assert property (p_mux4_pin)
      else $error("mux 4 code 5 does not pass pin D");

   property p_spi_gate;
      @(posedge clk_i) disable iff (rst_i)
      (sp.sel[2] == `LCIS_CODE3 && !spi1_sdo_routed_i) |-> !sp.out[2];
   endproperty
   a_spi_gate: assert property (p_spi_gate)
      else $error("unrouted spi output reached mux 3");

   property p_gate1_true;
      @(posedge clk_i) disable iff (rst_i)
      (gl_low_reg[7:0] == 8'h02 && !pol_reg[0]) |=> gate_o[0] == $past(sp.out[0]);
   endproperty
   a_gate1_true: assert property (p_gate1_true)
      else $error("gate 1 true source 1 wrong");

   property p_gate2_inv;
      @(posedge clk_i) disable iff (rst_i)
      (gl_low_reg[15:8] == 8'h01 && !pol_reg[1]) |=> gate_o[1] == !$past(sp.out[0]);
   endproperty
   a_gate2_inv: assert property (p_gate2_inv)
      else $error("gate 2 negated source 1 wrong");

   property p_gate3_src4;
      @(posedge clk_i) disable iff (rst_i)
      (gl_high_reg[7:0] == 8'h80 && !pol_reg[2]) |=> gate_o[2] == $past(sp.out[3]);
   endproperty
   a_gate3_src4: assert property (p_gate3_src4)
      else $error("gate 3 true source 4 wrong");

   property p_gate4_inv4;
      @(posedge clk_i) disable iff (rst_i)
      (gl_high_reg[15:8] == 8'h40 && !pol_reg[3]) |=> gate_o[3] == !$past(sp.out[3]);
   endproperty
   a_gate4_inv4: assert property (p_gate4_inv4)
      else $error("gate 4 negated source 4 wrong");

   property p_gate_empty;
      @(posedge clk_i) disable iff (rst_i)
      gl_low_reg[7:0] == 8'h00 |=> gate_o[0] == $past(pol_reg[0]);
   endproperty
   a_gate_empty: assert property (p_gate_empty)
      else $error("empty gate 1 not at polarity constant");

   property p_gate_pol;
      @(posedge clk_i) disable iff (rst_i)
      gl_high_reg[15:8] == 8'h03 |=> gate_o[3] == !$past(pol_reg[3]);
   endproperty
   a_gate_pol: assert property (p_gate_pol)
      else $error("gate 4 polarity not applied");

   property p_sel_read;
      @(posedge clk_i) disable iff (rst_i)
      (access && !wb_ack_o && !wb_we_i && byte_adr == `LCIS_OFF_SEL)
      |=> wb_ack_o && !wb_dat_o[15] && !wb_dat_o[11] && !wb_dat_o[7] && !wb_dat_o[3];
   endproperty
   a_sel_read: assert property (p_sel_read)
      else $error("source select read shows unimplemented bits");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

endmodule

// ---- sim/lcis_periph_model.sv ----
// Purpose: peripherals, pins and neighbouring cells that feed the cell
// Assumes: one clock; every source moves just after a rising edge
// Notes:   bit order of lvl_i follows the bench's source table
`timescale 1ns/10ps
module lcis_periph_model
(
   // clock and wanted levels
   input  wire logic        clk_i,
   input  wire logic [30:0] lvl_i,
   // source levels towards the cell
   output logic      [30:0] src_o = 31'h0
);
   ////////////////////////////////////////////////////////////////////////////////
   // registered so no source ever changes in the cell's sampling step
   always @(posedge clk_i)
   begin
      src_o <= lvl_i;
   end
endmodule

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench of the cell input side
// Assumes: 20 MHz clock, bus answer one cycle after the request is taken
// Notes:   pin paths take four edges with the model flop, so each level change gets five cycles
`timescale 1ns/10ps
`include "lcis_map.svh"
module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [3:0]  gate_o;
   logic [3:0]  mux_o;
   logic [30:0] lvl = 31'h0;
   logic [30:0] src;
   logic [31:0] q;
   int          err_total = 0;
   int          total_checks = 0;
   // source bit behind each mux code; 31 marks a reserved code
   int          map [0:3][0:7] = '{'{0, 9, 22, 10, 11, 7, 17, 19},
      '{1, 8, 4, 25, 31, 31, 12, 13}, '{2, 20, 5, 26, 24, 23, 14, 15},
      '{30, 21, 6, 27, 31, 3, 16, 18}};

   ////////////////////////////////////////////////////////////////////////////////
   lcis_periph_model peri (.clk_i(clk_i), .lvl_i(lvl), .src_o(src));
   lcis_top dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cell_pin_a_i(src[0]),
      .cell_pin_b_i(src[1]), .cell_pin_c_i(src[2]), .cell_pin_d_i(src[3]),
      .primary_cmp1_i(src[4]), .secondary_cmp1_i(src[5]), .secondary_cmp2_i(src[6]),
      .secondary_cmp3_i(src[7]), .remote_cell2_i(src[8]),
      .instruction_cycle_clock_i(src[9]), .internal_rc_clock_i(src[10]),
      .reference_clock_out_i(src[11]), .capture_event_flag_i(src[15:12]),
      .capture_aux_i(src[19:16]), .cell_out_i(src[23:20]), .uart1_rx_i(src[24]),
      .uart1_tx_i(src[25]), .spi1_sdo_i(src[26]), .spi1_sdi_i(src[27]),
      .spi1_sdo_routed_i(src[28]), .spi1_sdi_routed_i(src[29]),
      .pwm_event_a_i(src[30]), .gate_o(gate_o), .mux_o(mux_o)
   );

   initial
   begin
      forever #25 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      if (wb_ack_o !== 1'b1)
         chk("wb_ack_o", 32'h1, 32'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      wb(1'b0, a, 32'h0, 4'hf);
      chk(nm, exp, q);
   endtask

   // new levels, then wait out the two synchroniser flops
   task automatic settle(input logic [30:0] v);
      lvl <= v;
      repeat (5) @(posedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(`LCIS_OFF_SEL, 32'h0, "sel reset");
      rd(`LCIS_OFF_GLSL, 32'h0, "glsl reset");
      rd(`LCIS_OFF_GLSH, 32'h0, "glsh reset");
      rd(`LCIS_OFF_POL, 32'h0, "pol reset");
      wb(1'b1, 8'h14, 32'hffff, 4'h3);
      rd(8'h14, 32'h0, "unmapped");
      wb(1'b1, `LCIS_OFF_SEL, 32'hffff, 4'h3);
      rd(`LCIS_OFF_SEL, 32'h7777, "sel mask");
      wb(1'b1, `LCIS_OFF_GLSL, 32'habcd, 4'h1);
      rd(`LCIS_OFF_GLSL, 32'h00cd, "glsl lane");
      wb(1'b1, `LCIS_OFF_GLSH, 32'h1234, 4'h2);
      rd(`LCIS_OFF_GLSH, 32'h1200, "glsh lane");
   endtask

   // every code of every mux, selected source high with both spi routes, then low alone; reserved codes all high, then all low
   task automatic t_mux();
      int m;
      int c;
      for (m = 0; m < 4; m++)
         for (c = 0; c < 8; c++)
         begin
            wb(1'b1, `LCIS_OFF_SEL, 32'(c) << (4 * m), 4'h3);
            settle(map[m][c] == 31 ? 31'h7fffffff : (31'h1 << map[m][c]) | 31'h30000000);
            chk("mux_o high", {31'h0, map[m][c] != 31}, {31'h0, mux_o[m]});
            settle(map[m][c] == 31 ? 31'h0 : ~(31'h1 << map[m][c]));
            chk("mux_o low", 32'h0, {31'h0, mux_o[m]});
         end
   endtask

   task automatic t_spi();
      wb(1'b1, `LCIS_OFF_SEL, 32'h3300, 4'h3);
      settle(31'h0c000000);
      chk("spi unrouted", 32'h0, {28'h0, mux_o});
      settle(31'h3c000000);
      chk("spi routed", 32'hc, {28'h0, mux_o});
   endtask

   // one enable bit at a time over all gates, two opposite pin patterns
   task automatic t_gate();
      int         g;
      int         b;
      logic [3:0] p;
      logic [3:0] e;
      logic [31:0] w;
      p = 4'h5;
      wb(1'b1, `LCIS_OFF_SEL, 32'h5000, 4'h3);
      repeat (2)
      begin
         for (g = 0; g < 4; g++)
            for (b = 0; b < 8; b++)
            begin
               w = 32'h1 << (8 * (g % 2) + b);
               wb(1'b1, `LCIS_OFF_GLSL, g < 2 ? w : 32'h0, 4'h3);
               wb(1'b1, `LCIS_OFF_GLSH, g < 2 ? 32'h0 : w, 4'h3);
               settle({27'h0, p});
               e = 4'h0;
               e[g] = b[0] ? p[b / 2] : ~p[b / 2];
               chk("gate_o", {28'h0, e}, {28'h0, gate_o});
            end
         p = ~p;
      end
   endtask

   task automatic t_pol();
      wb(1'b1, `LCIS_OFF_GLSL, 32'h0, 4'h3);
      wb(1'b1, `LCIS_OFF_GLSH, 32'h0, 4'h3);
      wb(1'b1, `LCIS_OFF_POL, 32'h5, 4'h1);
      settle(31'h1);
      chk("gate_o empty", 32'h5, {28'h0, gate_o});
      // gate 4 takes source 1 true and negated together, so it is always high
      wb(1'b1, `LCIS_OFF_GLSL, 32'h0202, 4'h3);
      wb(1'b1, `LCIS_OFF_GLSH, 32'h0300, 4'h3);
      settle(31'h1);
      chk("gate_o pol", 32'he, {28'h0, gate_o});
      rd(`LCIS_OFF_STAT, 32'h1e, "status");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // whole run is near 1200 cycles; allow over sixteen times that
   initial
   begin
      #1000000;
      err_total++;
      test_done();
   end

   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("outputs in reset", 32'h0, {24'h0, mux_o, gate_o});
      t_regs();
      t_mux();
      t_spi();
      t_gate();
      t_pol();
      test_done();
   end
endmodule
